/* rtl/lmpa_regs.sv */
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "lmpa_consts.svh"
// Functional notes
// - die temperature read-only code; degrees equal code minus 67.
// - eight-bit bandgap trim, resets to zero, software writable.
// - both peak results clear when peak-track bit rises 0 to 1.
// - while peak-track is 1, detectors keep updating with new peaks.
// - when peak-track returns to 0, results freeze until set again.
// - voltage result is (largest positive plus largest negative peak) over 2.
// - current result is (largest positive plus largest negative peak) halved.
// - 12-bit result split: 11:4 main byte, 3:0 upper nibble of extra byte.
// - alarm counter increments on rising edge of either supply flag.
// - alarm counter saturates at 255, never wraps.
// - reading the alarm counter returns its value then subtracts it; flag rises after the read's setup are kept.
// - alarms from converter overvoltage, low supply voltage, high supply current.
// - pole coefficients 13 bits: low byte, shared mid nibble, shared top bit.
// - power filter runs only while its enable bit is 1.
// - feedback disable bit 6 opens impedance feedback loop; default 0 active.
// - peak-track is bit 5 of polarity register; 1 tracks, 0 holds, a 0 to 1 rise clears.
module lmpa_regs #(
	parameter int SAMPLE_W = 12
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] die_heat_code,
	input wire logic [SAMPLE_W-1:0] loop_voltage_sample,
	input wire logic loop_voltage_negative,
	input wire logic [SAMPLE_W-1:0] loop_current_sample,
	input wire logic loop_current_negative,
	input wire logic converter_overvoltage,
	input wire logic low_supply_voltage_flag,
	input wire logic high_supply_current_flag,
	input wire logic [7:0] pair1_power,
	input wire logic [7:0] pair2_power,
	input wire logic [7:0] pair3_power,
	output logic [7:0] reference_trim,
	output logic [3:0] matching_resistor_select,
	output logic [3:0] matching_resistor_code,
	output logic feedback_loop_disable,
	output logic [2:0] power_alarm,
	output logic irq
);
	lmpa_pkg::lmpa_state_t s;
	lmpa_pkg::lmpa_state_t next_s;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// word address to register index; misaligned or high bits unmapped
	function automatic logic [8:0] reg_index(input logic [31:0] a);
		if (a[1:0] != 2'b00 || a[31:10] != 22'h0) begin
			return 9'h100;
		end
		return {1'b0, a[9:2]};
	endfunction : reg_index

	// any index that answers without an error
	function automatic logic reg_mapped(input logic [8:0] i);
		unique case (i)
			9'(`LMPA_IDX_DIE_TEMPERATURE), 9'(`LMPA_IDX_BANDGAP_TRIM),
			9'(`LMPA_IDX_ALARM_COUNT), 9'(`LMPA_IDX_POLE_PAIR2_LOW),
			9'(`LMPA_IDX_POLE_PAIR1_LOW), 9'(`LMPA_IDX_POLE_PAIR3_LOW),
			9'(`LMPA_IDX_POLE_PAIRS12_MID), 9'(`LMPA_IDX_POLE_TOP_ENABLE),
			9'(`LMPA_IDX_THRESH_PAIR2), 9'(`LMPA_IDX_THRESH_PAIR1),
			9'(`LMPA_IDX_THRESH_PAIR3), 9'(`LMPA_IDX_IMP_RES_SELECT),
			9'(`LMPA_IDX_IMP_LOOP_CTRL), 9'(`LMPA_IDX_POLARITY),
			9'(`LMPA_IDX_VOLT_PEAK_HIGH), 9'(`LMPA_IDX_VOLT_PEAK_LOW),
			9'(`LMPA_IDX_CURR_PEAK_HIGH), 9'(`LMPA_IDX_CURR_PEAK_LOW),
			9'(`LMPA_IDX_IRQ_STATUS), 9'(`LMPA_IDX_IRQ_ENABLE),
			9'(`LMPA_IDX_IRQ_CLEAR): return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : reg_mapped

	// one-pole filter: est = est*pole/2^13 + sample - sample/2^13, in 20-bit fixed point
	function automatic logic [19:0] lpf_step(input logic [19:0] est,
			input logic [12:0] pole, input logic [7:0] p);
		logic [32:0] prod;
		prod = {13'h0, est} * {20'h0, pole};
		return 20'(prod[32:13]) + {p, 12'h0} - 20'({p, 12'h0} >> 13);
	endfunction : lpf_step

	// (max positive + max negative) / 2 with a carry bit kept
	function automatic logic [11:0] half_sum(input logic [11:0] a, input logic [11:0] b);
		logic [12:0] sum;
		sum = {1'b0, a} + {1'b0, b};
		return sum[12:1];
	endfunction : half_sum

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	logic [8:0] idx;
	logic wr_en;
	logic rd_en;
	logic track_rise;
	logic [3:0] events;
	logic [11:0] vs;
	logic [11:0] is;

	always_comb begin
		next_s = s;
		idx = reg_index(paddr);
		wr_en = psel && penable && pwrite;
		rd_en = psel && penable && !pwrite;
		vs = 12'(loop_voltage_sample);
		is = 12'(loop_current_sample);
		next_s.pready = psel && !penable; // one wait-free access phase
		// error decided at setup so that it stands together with pready
		next_s.pslverr = psel && !penable && !reg_mapped(idx);
		next_s.prdata = 32'h0;

		// register writes
		if (wr_en && s.pready) begin
			unique case (idx)
				9'(`LMPA_IDX_BANDGAP_TRIM): next_s.trim = pwdata[7:0];
				9'(`LMPA_IDX_POLE_PAIR2_LOW): next_s.pole2[7:0] = pwdata[7:0];
				9'(`LMPA_IDX_POLE_PAIR1_LOW): next_s.pole1[7:0] = pwdata[7:0];
				9'(`LMPA_IDX_POLE_PAIR3_LOW): next_s.pole3[7:0] = pwdata[7:0];
				9'(`LMPA_IDX_POLE_PAIRS12_MID): begin
					next_s.pole1[11:8] = pwdata[7:4];
					next_s.pole2[11:8] = pwdata[3:0];
				end
				9'(`LMPA_IDX_POLE_TOP_ENABLE): begin
					next_s.filter_en = pwdata[`LMPA_FILTER_ENABLE_BIT];
					next_s.pole3[12] = pwdata[6];
					next_s.pole1[12] = pwdata[5];
					next_s.pole2[12] = pwdata[4];
					next_s.pole3[11:8] = pwdata[3:0];
				end
				9'(`LMPA_IDX_THRESH_PAIR2): next_s.limit2 = pwdata[7:0];
				9'(`LMPA_IDX_THRESH_PAIR1): next_s.limit1 = pwdata[7:0];
				9'(`LMPA_IDX_THRESH_PAIR3): next_s.limit3 = pwdata[7:0];
				9'(`LMPA_IDX_IMP_RES_SELECT): next_s.res_sel = pwdata[3:0];
				9'(`LMPA_IDX_IMP_LOOP_CTRL):
					next_s.loop_dis = pwdata[`LMPA_FEEDBACK_DISABLE_BIT];
				9'(`LMPA_IDX_POLARITY): next_s.polarity = pwdata[7:0];
				9'(`LMPA_IDX_IRQ_ENABLE): next_s.irq_en = pwdata[3:0];
				9'(`LMPA_IDX_IRQ_CLEAR): next_s.irq_stat = s.irq_stat & ~pwdata[3:0];
				9'(`LMPA_IDX_DIE_TEMPERATURE), 9'(`LMPA_IDX_ALARM_COUNT),
				9'(`LMPA_IDX_VOLT_PEAK_HIGH), 9'(`LMPA_IDX_VOLT_PEAK_LOW),
				9'(`LMPA_IDX_CURR_PEAK_HIGH), 9'(`LMPA_IDX_CURR_PEAK_LOW),
				9'(`LMPA_IDX_IRQ_STATUS): ; // read-only, write ignored
				default: ;
			endcase
		end

		// read data captured at setup so it stands with pready in the access cycle
		if (psel && !penable && !pwrite) begin
			unique case (idx)
				9'(`LMPA_IDX_DIE_TEMPERATURE): next_s.prdata[7:0] = die_heat_code;
				9'(`LMPA_IDX_BANDGAP_TRIM): next_s.prdata[7:0] = s.trim;
				9'(`LMPA_IDX_ALARM_COUNT): next_s.prdata[7:0] = s.alarm_count;
				9'(`LMPA_IDX_POLE_PAIR2_LOW): next_s.prdata[7:0] = s.pole2[7:0];
				9'(`LMPA_IDX_POLE_PAIR1_LOW): next_s.prdata[7:0] = s.pole1[7:0];
				9'(`LMPA_IDX_POLE_PAIR3_LOW): next_s.prdata[7:0] = s.pole3[7:0];
				9'(`LMPA_IDX_POLE_PAIRS12_MID):
					next_s.prdata[7:0] = {s.pole1[11:8], s.pole2[11:8]};
				9'(`LMPA_IDX_POLE_TOP_ENABLE): next_s.prdata[7:0] =
					{s.filter_en, s.pole3[12], s.pole1[12], s.pole2[12], s.pole3[11:8]};
				9'(`LMPA_IDX_THRESH_PAIR2): next_s.prdata[7:0] = s.limit2;
				9'(`LMPA_IDX_THRESH_PAIR1): next_s.prdata[7:0] = s.limit1;
				9'(`LMPA_IDX_THRESH_PAIR3): next_s.prdata[7:0] = s.limit3;
				9'(`LMPA_IDX_IMP_RES_SELECT): next_s.prdata[7:0] = {4'h0, s.res_sel};
				9'(`LMPA_IDX_IMP_LOOP_CTRL):
					next_s.prdata[7:0] = {1'b0, s.loop_dis, 6'h0};
				9'(`LMPA_IDX_POLARITY): next_s.prdata[7:0] = s.polarity;
				9'(`LMPA_IDX_VOLT_PEAK_HIGH): next_s.prdata[7:0] = s.vswing[11:4];
				9'(`LMPA_IDX_VOLT_PEAK_LOW):
					next_s.prdata[7:0] = {s.vswing[3:0], 4'h0};
				9'(`LMPA_IDX_CURR_PEAK_HIGH): next_s.prdata[7:0] = s.iswing[11:4];
				9'(`LMPA_IDX_CURR_PEAK_LOW):
					next_s.prdata[7:0] = {s.iswing[3:0], 4'h0};
				9'(`LMPA_IDX_IRQ_STATUS): next_s.prdata[7:0] = {4'h0, s.irq_stat};
				9'(`LMPA_IDX_IRQ_ENABLE): next_s.prdata[7:0] = {4'h0, s.irq_en};
				9'(`LMPA_IDX_IRQ_CLEAR): next_s.prdata = 32'h0; // write-only
				default: ;
			endcase
		end

		// ------------------------------------------------------------
		// peak detectors
		// ------------------------------------------------------------
		// rising edge of track bit clears; tracking updates; low holds
		next_s.track_q = s.polarity[`LMPA_PEAK_TRACK_BIT];
		track_rise = s.polarity[`LMPA_PEAK_TRACK_BIT] && !s.track_q;
		if (track_rise) begin
			next_s.vmax = 12'h0;
			next_s.vmin = 12'h0;
			next_s.imax = 12'h0;
			next_s.imin = 12'h0;
			next_s.vswing = 12'h0;
			next_s.iswing = 12'h0;
		end else if (s.polarity[`LMPA_PEAK_TRACK_BIT]) begin
			if (!loop_voltage_negative && vs > s.vmax) next_s.vmax = vs;
			if (loop_voltage_negative && vs > s.vmin) next_s.vmin = vs;
			if (!loop_current_negative && is > s.imax) next_s.imax = is;
			if (loop_current_negative && is > s.imin) next_s.imin = is;
			next_s.vswing = half_sum(s.vmax, s.vmin);
			next_s.iswing = half_sum(s.imax, s.imin);
		end // else results held

		// ------------------------------------------------------------
		// power alarm counter and thermal filter
		// ------------------------------------------------------------
		next_s.flag_v_q = low_supply_voltage_flag;
		next_s.flag_i_q = high_supply_current_flag;
		events[0] = low_supply_voltage_flag && !s.flag_v_q;
		events[1] = high_supply_current_flag && !s.flag_i_q;
		events[2] = converter_overvoltage;
		// read clears only what was reported; later events are kept
		if (rd_en && s.pready && idx == 9'(`LMPA_IDX_ALARM_COUNT)) begin
			next_s.alarm_count = s.alarm_count - s.prdata[7:0]
				+ {7'h0, events[1:0] != 2'b00};
		end else if ((events[1:0] != 2'b00) && s.alarm_count != `LMPA_ALARM_MAX) begin
			next_s.alarm_count = s.alarm_count + 8'h01;
		end
		if (s.filter_en) begin
			next_s.est1 = lpf_step(s.est1, s.pole1, pair1_power);
			next_s.est2 = lpf_step(s.est2, s.pole2, pair2_power);
			next_s.est3 = lpf_step(s.est3, s.pole3, pair3_power);
		end else begin
			next_s.est1 = {pair1_power, 12'h0};
			next_s.est2 = {pair2_power, 12'h0};
			next_s.est3 = {pair3_power, 12'h0};
		end
		next_s.alarm[0] = s.est1[19:12] > s.limit1;
		next_s.alarm[1] = s.est2[19:12] > s.limit2;
		next_s.alarm[2] = s.est3[19:12] > s.limit3;
		events[3] = (s.alarm != 3'b000);

		// sticky interrupt status; a set beats a same-cycle clear
		next_s.irq_stat = next_s.irq_stat | events;
		next_s.irq = (s.irq_stat & s.irq_en) != 4'h0;

		// resistor decode
		unique case (s.res_sel)
			4'h0, 4'h2: next_s.res_code = lmpa_pkg::LMPA_R600;
			4'h1, 4'h3: next_s.res_code = lmpa_pkg::LMPA_R900;
			4'h4: next_s.res_code = lmpa_pkg::LMPA_R270;
			4'h5, 4'h6: next_s.res_code = lmpa_pkg::LMPA_R200;
			4'h7: next_s.res_code = lmpa_pkg::LMPA_R100;
			4'h8: next_s.res_code = lmpa_pkg::LMPA_R370;
			4'h9, 4'hb: next_s.res_code = lmpa_pkg::LMPA_R220;
			4'ha: next_s.res_code = lmpa_pkg::LMPA_R320;
			default: next_s.res_code = lmpa_pkg::LMPA_RUNUSED;
		endcase
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// synchronous reset: every field to zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from flip-flops
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign reference_trim = s.trim;
	assign matching_resistor_select = s.res_sel;
	assign matching_resistor_code = s.res_code;
	assign feedback_loop_disable = s.loop_dis;
	assign power_alarm = s.alarm;
	assign irq = s.irq;
endmodule : lmpa_regs

/* shared/lmpa_consts.svh */
`ifndef LMPA_CONSTS_SVH
`define LMPA_CONSTS_SVH
// register indices (printed offsets are not all multiples of four)
`define LMPA_IDX_DIE_TEMPERATURE 8'h99
`define LMPA_IDX_BANDGAP_TRIM 8'h9a
`define LMPA_IDX_ALARM_COUNT 8'h9f
`define LMPA_IDX_POLE_PAIR2_LOW 8'ha0
`define LMPA_IDX_POLE_PAIR1_LOW 8'ha1
`define LMPA_IDX_POLE_PAIR3_LOW 8'ha2
`define LMPA_IDX_POLE_PAIRS12_MID 8'ha3
`define LMPA_IDX_POLE_TOP_ENABLE 8'ha4
`define LMPA_IDX_THRESH_PAIR2 8'ha5
`define LMPA_IDX_THRESH_PAIR1 8'ha6
`define LMPA_IDX_THRESH_PAIR3 8'ha7
`define LMPA_IDX_IMP_RES_SELECT 8'ha8
`define LMPA_IDX_IMP_LOOP_CTRL 8'ha9
`define LMPA_IDX_POLARITY 8'h91
`define LMPA_IDX_VOLT_PEAK_HIGH 8'hb8
`define LMPA_IDX_VOLT_PEAK_LOW 8'hb9
`define LMPA_IDX_CURR_PEAK_HIGH 8'hba
`define LMPA_IDX_CURR_PEAK_LOW 8'hbb
`define LMPA_IDX_IRQ_STATUS 8'hbc
`define LMPA_IDX_IRQ_ENABLE 8'hbd
`define LMPA_IDX_IRQ_CLEAR 8'hbe
// field positions, temperature offset and alarm counter ceiling
`define LMPA_PEAK_TRACK_BIT 5
`define LMPA_FEEDBACK_DISABLE_BIT 6
`define LMPA_FILTER_ENABLE_BIT 7
`define LMPA_TEMP_OFFSET 8'd67
`define LMPA_ALARM_MAX 8'hff
// reset values
`define LMPA_RST_BYTE 8'h00
`endif

/* shared/lmpa_pkg.sv */
package lmpa_pkg;
	// apb request as seen by the slave
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} lmpa_apb_req_t;

	// impedance matching resistor settings
	typedef enum logic [3:0] {
		LMPA_R600 = 4'h0,
		LMPA_R900 = 4'h1,
		LMPA_R270 = 4'h2,
		LMPA_R200 = 4'h3,
		LMPA_R100 = 4'h4,
		LMPA_R370 = 4'h5,
		LMPA_R220 = 4'h6,
		LMPA_R320 = 4'h7,
		LMPA_RUNUSED = 4'hf
	} lmpa_res_t;

	// whole register state of the block
	typedef struct packed {
		logic [7:0] trim;
		logic [7:0] alarm_count;
		logic [12:0] pole1;
		logic [12:0] pole2;
		logic [12:0] pole3;
		logic filter_en;
		logic [7:0] limit1;
		logic [7:0] limit2;
		logic [7:0] limit3;
		logic [3:0] res_sel;
		logic loop_dis;
		logic [7:0] polarity;
		logic track_q;
		logic [11:0] vmax;
		logic [11:0] vmin;
		logic [11:0] vswing;
		logic [11:0] imax;
		logic [11:0] imin;
		logic [11:0] iswing;
		logic flag_v_q;
		logic flag_i_q;
		logic [19:0] est1;
		logic [19:0] est2;
		logic [19:0] est3;
		logic [2:0] alarm;
		logic [3:0] irq_stat;
		logic [3:0] irq_en;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		lmpa_res_t res_code;
	} lmpa_state_t;
endpackage : lmpa_pkg

/* testbench/lmpa_regs_properties.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checks of the register bank
// ------------------------------------------------------------
module lmpa_regs_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic [7:0] die_heat_code,
	input wire logic [7:0] reference_trim,
	input wire logic [3:0] matching_resistor_select,
	input wire logic [3:0] matching_resistor_code,
	input wire logic feedback_loop_disable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// completed write, qualifies the write-side checks
	logic acc;
	assign acc = psel && penable && pready && pwrite;
	a_pready_single: assert property (pready |=> !pready) else $error("pready held");
	a_answer_next: assert property (psel && !penable |=> pready) else $error("no answer");
	a_trim_write: assert property (acc && paddr == 32'h268 |=>
		reference_trim == $past(pwdata[7:0])) else $error("trim not written");
	a_trim_hold: assert property (!(acc && paddr == 32'h268) |=>
		$stable(reference_trim)) else $error("trim moved");
	a_loop_disable: assert property (acc && paddr == 32'h2a4 |=>
		feedback_loop_disable == $past(pwdata[6])) else $error("loop bit wrong");
	a_res_unused: assert property (matching_resistor_select[3:2] == 2'b11 |=>
		matching_resistor_code == 4'hf) else $error("unused code wrong");
	a_temp_live: assert property (psel && !penable && !pwrite && paddr == 32'h264 |=>
		prdata == {24'h0, $past(die_heat_code)}) else $error("temp read wrong");
	a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
endmodule : lmpa_regs_chk

bind lmpa_regs lmpa_regs_chk i_lmpa_regs_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .die_heat_code, .reference_trim,
	.matching_resistor_select, .matching_resistor_code, .feedback_loop_disable);

/* testbench/tb_lmpa_regs.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// self-checking bench, random data from a fixed seed
// ------------------------------------------------------------
module tb_lmpa_regs;
	logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
	logic pready, pslverr, feedback_loop_disable, irq, e;
	logic [11:0] loop_voltage_sample = 12'h0, loop_current_sample = 12'h0;
	logic loop_voltage_negative = 1'b0, loop_current_negative = 1'b0, converter_overvoltage = 1'b0;
	logic low_supply_voltage_flag = 1'b0, high_supply_current_flag = 1'b0;
	logic [7:0] die_heat_code = 8'h0, pair1_power = 8'h0, pair2_power = 8'h0, pair3_power = 8'h0;
	logic [7:0] reference_trim, q, d;
	logic [3:0] matching_resistor_select, matching_resistor_code;
	logic [2:0] power_alarm;
	logic [12:0] pk, nk;
	logic [7:0] rz[8] = '{8'h9a, 8'h9f, 8'ha1, 8'ha2, 8'ha5, 8'ha6, 8'ha7, 8'ha9};
	logic [7:0] rw[9] = '{8'h9a, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7};
	int err_count = 0, cmp_count = 0, cyc = 0, n;
	lmpa_regs #(.SAMPLE_W(12)) i_lmpa_regs (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .die_heat_code, .loop_voltage_sample,
		.loop_voltage_negative, .loop_current_sample, .loop_current_negative,
		.converter_overvoltage, .low_supply_voltage_flag, .high_supply_current_flag,
		.pair1_power, .pair2_power, .pair3_power, .reference_trim, .matching_resistor_select,
		.matching_resistor_code, .feedback_loop_disable, .power_alarm, .irq);
	// clock and hang guard; ceiling well above the run of about 830 cycles
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, x);
		end
	endtask : chk
	// one apb transfer; waits for pready, no fixed latency assumed
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
		int k;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {22'h0, a, 2'b00};
		pwdata <= {24'h0, v};
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		// look mid-cycle, so the answer is settled before its sampling edge
		do begin
			@(negedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			err_count++;
		end
		q = prdata[7:0];
		e = pslverr;
		@(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		apb(1'b0, a, 8'h0);
		chk({24'h0, q}, {24'h0, x});
	endtask : rd
	task automatic rdp(input logic [7:0] a, input logic [11:0] x);
		rd(a, x[11:4]);
		rd(a + 8'h1, {x[3:0], 4'h0});
	endtask : rdp
	task automatic tick(input int c);
		repeat (c) @(posedge ref_clk);
	endtask : tick
	// one supply flag pulse, low again for a cycle before the next rise
	task automatic pls(input logic f);
		@(posedge ref_clk);
		low_supply_voltage_flag <= !f;
		high_supply_current_flag <= f;
		@(posedge ref_clk);
		low_supply_voltage_flag <= 1'b0;
		high_supply_current_flag <= 1'b0;
	endtask : pls
	task automatic smp(input logic [11:0] m, input logic s);
		@(posedge ref_clk);
		loop_voltage_sample <= m;
		loop_current_sample <= m;
		loop_voltage_negative <= s;
		loop_current_negative <= s;
	endtask : smp
	function automatic logic [3:0] rcode(input logic [3:0] s);
		case (s)
			4'h0, 4'h2: return 4'h0;
			4'h1, 4'h3: return 4'h1;
			4'h4: return 4'h2;
			4'h5, 4'h6: return 4'h3;
			4'h7: return 4'h4;
			4'h8: return 4'h5;
			4'h9, 4'hb: return 4'h6;
			4'ha: return 4'h7;
			default: return 4'hf;
		endcase
	endfunction : rcode
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(85729));
		tick(16);
		rst_n <= 1'b1;
		foreach (rz[i]) rd(rz[i], 8'h0);
		foreach (rw[i]) begin
			d = 8'($urandom);
			apb(1'b1, rw[i], d);
			rd(rw[i], d);
		end
		die_heat_code <= 8'($urandom);
		apb(1'b1, 8'h99, 8'h5a);
		rd(8'h99, die_heat_code);
		apb(1'b0, 8'h00, 8'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b1, 8'ha9, 8'h40);
		tick(2);
		chk({31'h0, feedback_loop_disable}, 32'h1);
		apb(1'b1, 8'ha9, 8'h00);
		tick(2);
		chk({31'h0, feedback_loop_disable}, 32'h0);
		for (int s = 0; s < 16; s++) begin
			apb(1'b1, 8'ha8, 8'(s));
			tick(2);
			chk({28'h0, matching_resistor_code}, {28'h0, rcode(4'(s))});
		end
		n = 1 + $urandom % 6;
		repeat (n) pls(1'($urandom));
		tick(2);
		rd(8'h9f, 8'(n));
		rd(8'h9f, 8'h0);
		repeat (260) pls(1'b0);
		tick(2);
		rd(8'h9f, 8'hff);
		apb(1'b1, 8'hbd, 8'h01);
		pls(1'b0);
		tick(3);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 8'hbe, 8'h01);
		tick(3);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, 8'hbd, 8'h00);
		pls(1'b1);
		tick(3);
		chk({31'h0, irq}, 32'h0);
		rd(8'hbc, 8'h02);
		rd(8'h9f, 8'h02);
		apb(1'b1, 8'h91, 8'h20);
		pk = {1'b0, 12'($urandom)};
		nk = {1'b0, 12'($urandom)};
		smp(pk[11:0] >> 1, 1'b0);
		smp(pk[11:0], 1'b0);
		smp(nk[11:0], 1'b1);
		smp(12'h0, 1'b0);
		tick(3);
		rdp(8'hb8, 12'((pk + nk) >> 1));
		rdp(8'hba, 12'((pk + nk) >> 1));
		apb(1'b1, 8'h91, 8'h00);
		smp(12'hfff, 1'b0);
		smp(12'hfff, 1'b1);
		smp(12'h0, 1'b0);
		tick(3);
		rdp(8'hb8, 12'((pk + nk) >> 1));
		apb(1'b1, 8'h91, 8'h20);
		tick(3);
		rdp(8'hba, 12'h0);
		apb(1'b1, 8'ha4, 8'h00);
		apb(1'b1, 8'ha6, 8'h10);
		apb(1'b1, 8'ha5, 8'hff);
		pair1_power <= 8'h80;
		pair2_power <= 8'hff;
		tick(4);
		chk({29'h0, power_alarm}, 32'h1);
		pair1_power <= 8'h10;
		tick(4);
		chk({29'h0, power_alarm}, 32'h0);
		finish_test();
	end
endmodule : tb_lmpa_regs
